// >>> pmd_pkg.sv
// package for the paged memory decoder: offsets, fields, reset values, carriers
package pmd_pkg;
	// apb register byte offsets
	localparam logic [11:0] PMD_OFF_MAIN_CFG = 12'h000;
	localparam logic [11:0] PMD_OFF_BOOT_CFG = 12'h004;
	localparam logic [11:0] PMD_OFF_SRAM_BASE = 12'h008;
	localparam logic [11:0] PMD_OFF_IO_BASE = 12'h00C;
	localparam logic [11:0] PMD_OFF_REP_WIN = 12'h010;
	localparam logic [11:0] PMD_OFF_PORT_MODE = 12'h014;
	localparam logic [11:0] PMD_OFF_STATUS = 12'h018;
	// offsets inside the 256-byte control window
	localparam logic [7:0] PMD_IO_MAP_OFF = 8'hB0;
	localparam logic [7:0] PMD_IO_PAGE_OFF = 8'hC0;
	localparam logic [5:0] PMD_IO_PORT_WORD = 6'h00;
	// space map field positions
	localparam int PMD_MAP_MAIN_CODE = 0;
	localparam int PMD_MAP_MAIN_DATA = 1;
	localparam int PMD_MAP_BOOT_CODE = 2;
	localparam int PMD_MAP_BOOT_DATA = 3;
	// port mode register field positions
	localparam int PMD_PM_HI_ADDR_EN = 4;
	// reset values
	localparam logic [3:0] PMD_MAP_INIT = 4'h6;
	localparam logic PMD_MAIN_HI_RST = 1'b1;
	localparam logic PMD_BOOT_HI_RST = 1'b0;
	localparam logic [2:0] PMD_SRAM_BASE_RST = 3'h1;
	localparam logic [7:0] PMD_IO_BASE_RST = 8'h40;
	localparam logic [7:0] PMD_REP_LO_RST = 8'hFF;
	localparam logic [7:0] PMD_REP_HI_RST = 8'h00;
	localparam logic [3:0] PMD_PORT_MODE_RST = 4'h0;
	localparam logic [7:0] PMD_PAGE_RST = 8'h00;

	// processor access as seen by the decoder
	typedef struct packed {
		logic [15:0] addr;
		logic rd;
		logic wr;
		logic psen;
		logic [7:0] wdata;
	} pmd_core_s;

	// segment selects
	typedef struct packed {
		logic [7:0] main_flash;
		logic [3:0] boot_flash;
		logic sram;
		logic io_block;
		logic repeater;
	} pmd_sel_s;
endpackage

// >>> pmd_decode.sv
// paged memory decoder with apb configuration and control window
//
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module pmd_decode #(
	parameter logic [3:0] MAP_INIT = pmd_pkg::PMD_MAP_INIT
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire pmd_pkg::pmd_core_s core,
	output logic [7:0] core_rdata,
	output pmd_pkg::pmd_sel_s selects,
	input wire logic [7:0] repeater_pin_in,
	output logic [7:0] repeater_pin_out,
	output logic repeater_pin_oe,
	output logic [11:0] addr_low_out,
	output logic [3:0] macrocell_addr_hi,
	input wire logic [31:0] pld_port_out,
	output logic [31:0] port_out
);
	import pmd_pkg::*;

	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		logic cfg_main_hi;
		logic cfg_boot_hi;
		logic [2:0] cfg_sram_base;
		logic [7:0] cfg_io_base;
		logic [7:0] cfg_rep_lo;
		logic [7:0] cfg_rep_hi;
		logic [3:0] cfg_port_mode;
		logic cfg_hi_addr_en;
		logic [3:0] space_map_register;
		logic [7:0] page;
		logic [31:0] port_data;
		pmd_sel_s sel;
		logic [7:0] core_rdata;
		logic [7:0] rep_out;
		logic rep_oe;
		logic [7:0] rep_sync1;
		logic [7:0] rep_sync2;
		logic [7:0] rep_sync3;
		logic [7:0] rep_stable;
		logic [11:0] addr_low;
		logic [3:0] addr_hi;
		logic [31:0] port_out;
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
	} pmd_state_s;

	pmd_state_s st;
	pmd_state_s next_st;
	logic data_acc;
	logic code_acc;
	logic io_hit;
	logic sram_hit;
	logic main_space;
	logic boot_space;
	logic main_hit;
	logic boot_hit;
	logic rep_hit;
	logic apb_mapped;
	logic [31:0] apb_rmux;
	logic [31:0] port_mux;

	// ************************************************************
	// address decode
	// ************************************************************
	// strobes qualify every internal select
	assign data_acc = core.rd | core.wr;
	assign code_acc = core.psen;
	// control window has top priority, then sram, then flash
	assign io_hit = data_acc && (core.addr[15:8] == st.cfg_io_base);
	assign sram_hit = data_acc && (core.addr[15:13] == st.cfg_sram_base) && !io_hit;
	// fetch strobe for code space, read and write strobes for data space
	assign main_space = (st.space_map_register[PMD_MAP_MAIN_CODE] & code_acc) |
		(st.space_map_register[PMD_MAP_MAIN_DATA] & data_acc);
	assign boot_space = (st.space_map_register[PMD_MAP_BOOT_CODE] & code_acc) |
		(st.space_map_register[PMD_MAP_BOOT_DATA] & data_acc);
	// main flash banked by the low page bits, page bit 3 must be clear
	assign main_hit = main_space && (core.addr[15] == st.cfg_main_hi) && !st.page[3] &&
		!io_hit && !sram_hit;
	// boot flash is page independent
	assign boot_hit = boot_space && (core.addr[15] == st.cfg_boot_hi) && !io_hit && !sram_hit &&
		!main_hit;
	// repeater window is an inclusive range of 256-byte blocks
	assign rep_hit = data_acc && (core.addr[15:8] >= st.cfg_rep_lo) &&
		(core.addr[15:8] <= st.cfg_rep_hi) && !io_hit;

	// ************************************************************
	// port source selection
	// ************************************************************
	// each port takes either its control register or the logic output
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_port
			assign port_mux[gi*8 +: 8] = st.cfg_port_mode[gi] ? pld_port_out[gi*8 +: 8] :
				st.port_data[gi*8 +: 8];
		end
	endgenerate

	// ************************************************************
	// apb read mux
	// ************************************************************
	// address decode for the configuration registers
	always_comb begin
		apb_mapped = 1'b1;
		apb_rmux = 32'h0;
		if (paddr == PMD_OFF_MAIN_CFG) begin
			apb_rmux = {31'h0, st.cfg_main_hi};
		end else if (paddr == PMD_OFF_BOOT_CFG) begin
			apb_rmux = {31'h0, st.cfg_boot_hi};
		end else if (paddr == PMD_OFF_SRAM_BASE) begin
			apb_rmux = {29'h0, st.cfg_sram_base};
		end else if (paddr == PMD_OFF_IO_BASE) begin
			apb_rmux = {24'h0, st.cfg_io_base};
		end else if (paddr == PMD_OFF_REP_WIN) begin
			apb_rmux = {16'h0, st.cfg_rep_hi, st.cfg_rep_lo};
		end else if (paddr == PMD_OFF_PORT_MODE) begin
			apb_rmux = {27'h0, st.cfg_hi_addr_en, st.cfg_port_mode};
		end else if (paddr == PMD_OFF_STATUS) begin
			apb_rmux = {20'h0, st.space_map_register, st.page};
		end else begin
			apb_mapped = 1'b0;
		end
	end

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		next_st = st;
		// apb: one wait state, then pready for one cycle
		next_st.pready = 1'b0;
		next_st.prdata = 32'h0;
		next_st.pslverr = 1'b0;
		if (psel && penable && !st.pready) begin
			next_st.pready = 1'b1;
			next_st.prdata = pwrite ? 32'h0 : apb_rmux;
			next_st.pslverr = !apb_mapped;
		end
		// writes land on the edge that samples pready high
		if (psel && penable && st.pready && pwrite) begin
			if (paddr == PMD_OFF_MAIN_CFG) begin
				next_st.cfg_main_hi = pwdata[0];
			end else if (paddr == PMD_OFF_BOOT_CFG) begin
				next_st.cfg_boot_hi = pwdata[0];
			end else if (paddr == PMD_OFF_SRAM_BASE) begin
				next_st.cfg_sram_base = pwdata[2:0];
			end else if (paddr == PMD_OFF_IO_BASE) begin
				next_st.cfg_io_base = pwdata[7:0];
			end else if (paddr == PMD_OFF_REP_WIN) begin
				next_st.cfg_rep_lo = pwdata[7:0];
				next_st.cfg_rep_hi = pwdata[15:8];
			end else if (paddr == PMD_OFF_PORT_MODE) begin
				next_st.cfg_port_mode = pwdata[3:0];
				next_st.cfg_hi_addr_en = pwdata[PMD_PM_HI_ADDR_EN];
			end
		end
		// processor writes into the control window
		if (core.wr && io_hit) begin
			if (core.addr[7:0] == PMD_IO_PAGE_OFF) begin
				next_st.page = core.wdata;
			end else if (core.addr[7:0] == PMD_IO_MAP_OFF) begin
				next_st.space_map_register = core.wdata[3:0];
			end else if (core.addr[7:2] == PMD_IO_PORT_WORD) begin
				next_st.port_data[core.addr[1:0]*8 +: 8] = core.wdata;
			end
		end
		// registered selects for this access
		next_st.sel.main_flash = main_hit ? (8'h01 << st.page[2:0]) : 8'h00;
		next_st.sel.boot_flash = boot_hit ? (4'h1 << core.addr[14:13]) : 4'h0;
		next_st.sel.sram = sram_hit;
		next_st.sel.io_block = io_hit;
		next_st.sel.repeater = rep_hit;
		// repeater input: three stages, accepted once the last two agree
		next_st.rep_sync1 = repeater_pin_in;
		next_st.rep_sync2 = st.rep_sync1;
		next_st.rep_sync3 = st.rep_sync2;
		if (st.rep_sync2 == st.rep_sync3) begin
			next_st.rep_stable = st.rep_sync3;
		end
		// repeater drives the pins only on writes inside its window
		next_st.rep_oe = rep_hit && core.wr;
		next_st.rep_out = (rep_hit && core.wr) ? core.wdata : 8'h00;
		// read data back to the core
		next_st.core_rdata = 8'h00;
		if (core.rd && io_hit) begin
			if (core.addr[7:0] == PMD_IO_PAGE_OFF) begin
				next_st.core_rdata = st.page;
			end else if (core.addr[7:0] == PMD_IO_MAP_OFF) begin
				next_st.core_rdata = {4'h0, st.space_map_register};
			end else if (core.addr[7:2] == PMD_IO_PORT_WORD) begin
				next_st.core_rdata = st.port_data[core.addr[1:0]*8 +: 8];
			end
		end else if (core.rd && rep_hit) begin
			next_st.core_rdata = st.rep_stable;
		end
		// dedicated low address pins, upper bits through macrocells only
		next_st.addr_low = core.addr[11:0];
		next_st.addr_hi = st.cfg_hi_addr_en ? core.addr[15:12] : 4'h0;
		next_st.port_out = port_mux;
	end

	// ************************************************************
	// state register
	// ************************************************************
	// reset loads the space map from MAP_INIT, not the value last written by the core
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
			st.cfg_main_hi <= PMD_MAIN_HI_RST;
			st.cfg_boot_hi <= PMD_BOOT_HI_RST;
			st.cfg_sram_base <= PMD_SRAM_BASE_RST;
			st.cfg_io_base <= PMD_IO_BASE_RST;
			st.cfg_rep_lo <= PMD_REP_LO_RST;
			st.cfg_rep_hi <= PMD_REP_HI_RST;
			st.cfg_port_mode <= PMD_PORT_MODE_RST;
			st.space_map_register <= MAP_INIT;
			st.page <= PMD_PAGE_RST;
		end else begin
			st <= next_st;
		end
	end

	// outputs straight from the state register
	assign prdata = st.prdata;
	assign pready = st.pready;
	assign pslverr = st.pslverr;
	assign core_rdata = st.core_rdata;
	assign selects = st.sel;
	assign repeater_pin_out = st.rep_out;
	assign repeater_pin_oe = st.rep_oe;
	assign addr_low_out = st.addr_low;
	assign macrocell_addr_hi = st.addr_hi;
	assign port_out = st.port_out;

	// ************************************************************
	// checks
	// ************************************************************
	chk_main_onehot: assert property (@(posedge clk) disable iff (!rst_n)
		$onehot0(selects.main_flash))
		else $error("main flash selects not one-hot");

	chk_boot_segment: assert property (@(posedge clk) disable iff (!rst_n)
		(|selects.boot_flash) |-> selects.boot_flash == (4'h1 << $past(core.addr[14:13])))
		else $error("boot segment does not match address");

	chk_sram_base: assert property (@(posedge clk) disable iff (!rst_n)
		selects.sram |-> $past(core.addr[15:13]) == $past(st.cfg_sram_base))
		else $error("sram select outside its window");

	chk_io_window: assert property (@(posedge clk) disable iff (!rst_n)
		selects.io_block |-> $past(core.addr[15:8]) == $past(st.cfg_io_base) && !selects.sram)
		else $error("control window select misplaced");

	chk_page_write: assert property (@(posedge clk) disable iff (!rst_n)
		(core.wr && io_hit && core.addr[7:0] == PMD_IO_PAGE_OFF) |=> st.page == $past(core.wdata))
		else $error("page write not taken");

	chk_main_page: assert property (@(posedge clk) disable iff (!rst_n)
		(|selects.main_flash) |-> selects.main_flash == (8'h01 << $past(st.page[2:0])) && !$past(st.page[3]))
		else $error("main segment does not follow page");

	chk_strobe_space: assert property (@(posedge clk) disable iff (!rst_n)
		(|selects.main_flash) |-> ($past(core.psen) && $past(st.space_map_register[PMD_MAP_MAIN_CODE])) ||
			($past(data_acc) && $past(st.space_map_register[PMD_MAP_MAIN_DATA])))
		else $error("main flash selected in wrong space");

	chk_no_strobe: assert property (@(posedge clk) disable iff (!rst_n)
		!(core.rd || core.wr || core.psen) |=> selects == '0)
		else $error("select without strobe");

	chk_rep_window: assert property (@(posedge clk) disable iff (!rst_n)
		repeater_pin_oe |-> $past(core.wr) && $past(core.addr[15:8]) >= $past(st.cfg_rep_lo) &&
			$past(core.addr[15:8]) <= $past(st.cfg_rep_hi))
		else $error("repeater driven outside window");

	chk_map_write: assert property (@(posedge clk) disable iff (!rst_n)
		(core.wr && io_hit && core.addr[7:0] == PMD_IO_MAP_OFF) |=>
			st.space_map_register == $past(core.wdata[3:0]))
		else $error("space map write not taken");

	chk_addr_low: assert property (@(posedge clk) disable iff (!rst_n)
		core.psen |=> addr_low_out == $past(core.addr[11:0]))
		else $error("low address pins wrong");

	chk_apb_answer: assert property (@(posedge clk) disable iff (!rst_n)
		(psel && penable && !pready) |=> pready ##1 !pready)
		else $error("apb answer not one wait state");
endmodule
`default_nettype wire

// >>> pmd_core_model.sv
// processor core model: one code or data access per call
`timescale 1ns/10ps
`default_nettype none
module pmd_core_model (
	input wire logic clk,
	output pmd_pkg::pmd_core_s core,
	output logic note
);
	import pmd_pkg::*;
	// ************
	// access driver
	// ************
	// idle bus at time zero
	initial begin
		core = '0;
		note = 1'b0;
	end
	// page and map writes may come at any time
	task automatic access(input logic [15:0] a, input logic r, w, p, input logic [7:0] d);
		@(posedge clk);
		core <= '{addr: a, rd: r, wr: w, psen: p, wdata: d};
		note <= 1'b1;
		@(posedge clk);
		core <= '{addr: ~a, rd: 1'b0, wr: 1'b0, psen: 1'b0, wdata: ~d}; // released bus, no stale value
		note <= 1'b0;
	endtask
endmodule
`default_nettype wire

// >>> tb_top.sv
// self-checking bench for the paged memory decoder
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import pmd_pkg::*;
	typedef struct packed {
		pmd_sel_s s;
		logic oe;
		logic [11:0] lo;
		logic [3:0] hi;
		logic [31:0] pb;
		logic [7:0] ro;
		logic [7:0] rd;
	} pmd_exp_s;
	logic clk, rst_n, psel, penable, pwrite, pready, pslverr, note, note_d, rep_oe, pv;
	logic [11:0] paddr, addr_lo;
	logic [31:0] pwdata, prdata, pld, port_out;
	logic [7:0] core_rdata, rep_in, rep_out, pg, iob, rlo, rhi, pb;
	logic [3:0] addr_hi, map;
	logic [2:0] sb;
	logic [4:0] pm;
	pmd_core_s core;
	pmd_sel_s selects;
	pmd_exp_s ex;
	pmd_exp_s sel_q[$];
	logic [32:0] apb_q[$];
	int fails = 0, compares = 0, cyc = 0, seed;
	logic [11:0] ra[8] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010, 12'h014, 12'h018, 12'h01C};
	logic [32:0] rv[8] = '{33'h1, 33'h0, 33'h1, 33'h40, 33'hFF, 33'h0, 33'h600, 33'h1_0000_0000};
	pmd_decode dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .core(core), .core_rdata(core_rdata),
		.selects(selects), .repeater_pin_in(rep_in), .repeater_pin_out(rep_out), .repeater_pin_oe(rep_oe),
		.addr_low_out(addr_lo), .macrocell_addr_hi(addr_hi), .pld_port_out(pld), .port_out(port_out));
	pmd_core_model cm (.clk(clk), .core(core), .note(note));
	// ************
	// shared tasks
	// ************
	task automatic chk(string n, logic [63:0] s, logic [63:0] e);
		compares++;
		if (s !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic end_sim();
		chk("queues", 64'(apb_q.size() + sel_q.size()), 64'h0);
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic apb(logic w, logic [11:0] a, logic [31:0] d, logic [32:0] e);
		if (!w) apb_q.push_back(e);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// expected selects from address, strobes and space map
	function automatic pmd_sel_s dec(logic [15:0] a, logic r, w, p);
		pmd_sel_s s;
		logic d;
		s = '0;
		d = r | w;
		if (d && a[15:8] == iob) s.io_block = 1'b1;
		else if (d && a[15:13] == sb) s.sram = 1'b1;
		else if (((d && map[1]) || (p && map[0])) && a[15] && !pg[3]) s.main_flash = 8'h01 << pg[2:0];
		else if (((d && map[3]) || (p && map[2])) && !a[15]) s.boot_flash = 4'h1 << a[14:13];
		if (d && a[15:8] >= rlo && a[15:8] <= rhi) s.repeater = 1'b1;
		return s;
	endfunction
	task automatic acc(logic [15:0] a, logic r, w, p, logic [7:0] d);
		pmd_exp_s e;
		logic io;
		e.s = dec(a, r, w, p);
		io = r && e.s.io_block;
		e.oe = w & e.s.repeater;
		e.lo = a[11:0];
		e.hi = pm[4] ? a[15:12] : 4'h0;
		// port bytes: logic side when its mode bit is set, else the control register
		for (int k = 0; k < 4; k++) e.pb[k*8 +: 8] = pm[k] ? pld[k*8 +: 8] : 8'h00;
		if (!pm[0] && pv) e.pb[7:0] = pb;
		e.ro = e.oe ? d : 8'h00;
		// read data: control window registers, else synchronised repeater pins
		e.rd = 8'h00;
		if (io && a[7:0] == PMD_IO_PAGE_OFF) e.rd = pg;
		else if (io && a[7:0] == PMD_IO_MAP_OFF) e.rd = {4'h0, map};
		else if (io && a[7:0] == 8'h00 && pv) e.rd = pb;
		else if (r && !e.s.io_block && e.s.repeater) e.rd = rep_in;
		sel_q.push_back(e);
		if (w && e.s.io_block && a[7:0] == PMD_IO_PAGE_OFF) pg = d;
		if (w && e.s.io_block && a[7:0] == PMD_IO_MAP_OFF) map = d[3:0];
		if (w && e.s.io_block && a[7:0] == 8'h00) {pv, pb} = {1'b1, d};
		cm.access(a, r, w, p, d);
	endtask
	task automatic st_rst();
		{map, pg, iob, rlo, rhi, pm, pv} = {PMD_MAP_INIT, 8'h00, PMD_IO_BASE_RST, 8'hFF, 8'h00, 5'h00, 1'b0};
		sb = PMD_SRAM_BASE_RST;
	endtask
	// ************
	// clock, monitors, timeout
	// ************
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// apb answer checked at the pready edge
	always @(posedge clk) begin
		note_d <= note;
		cyc++;
		if (cyc == 5000) begin
			fails++;
			end_sim();
		end
		if (pready === 1'b1 && pwrite === 1'b0) chk("apb", {pslverr, prdata}, apb_q.pop_front());
	end
	// core results one cycle after the access
	always @(negedge clk) begin
		if (note_d === 1'b1) begin
			ex = sel_q.pop_front();
			chk("selects", selects, ex.s);
			chk("pin_oe", rep_oe, ex.oe);
			chk("addr_low", addr_lo, ex.lo);
			chk("addr_hi", addr_hi, ex.hi);
			chk("port_out", port_out, ex.pb);
			chk("pin_out", rep_out, ex.ro);
			chk("core_rdata", core_rdata, ex.rd);
		end
	end
	// ************
	// main sequence
	// ************
	initial begin
		{rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
		note_d = 1'b0;
		st_rst();
		pb = 8'h00;
		seed = $urandom(32'hB4730BD6);
		pld = $urandom;
		rep_in = 8'($urandom);
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 8; i++) apb(1'b0, ra[i], 32'h0, rv[i]);
		apb(1'b1, PMD_OFF_STATUS, 32'hFFFF, 33'h0);
		apb(1'b0, PMD_OFF_STATUS, 32'h0, 33'h600);
		for (int i = 0; i < 8; i++) begin
			acc(16'($urandom) & 16'h7FFF, 1'b0, 1'b0, 1'b1, 8'h00);
			acc(16'($urandom) & 16'h1FFF, 1'b1, 1'b0, 1'b0, 8'h00);
			acc(16'h8000 | 16'($urandom), 1'b0, 1'b0, 1'b1, 8'h00);
		end
		for (int i = 0; i < 10; i++) begin
			acc(16'h40C0, 1'b0, 1'b1, 1'b0, (i < 8) ? 8'(i) : (i == 8 ? 8'h08 : 8'h12));
			acc(16'h8000 | 16'($urandom), 1'b1, 1'b0, 1'b0, 8'h00);
		end
		acc(16'h2000 | (16'($urandom) & 16'h1FFF), 1'b1, 1'b0, 1'b0, 8'h00);
		acc(16'h4010, 1'b1, 1'b0, 1'b0, 8'h00);
		acc(16'h4010, 1'b0, 1'b0, 1'b0, 8'h00);
		apb(1'b1, PMD_OFF_REP_WIN, 32'h6060, 33'h0);
		{rlo, rhi} = 16'h6060;
		acc(16'h6055, 1'b0, 1'b1, 1'b0, 8'hA5);
		acc(16'h6100, 1'b0, 1'b1, 1'b0, 8'h5A);
		apb(1'b1, PMD_OFF_IO_BASE, 32'h50, 33'h0);
		iob = 8'h50;
		acc(16'h5000, 1'b0, 1'b1, 1'b0, 8'(seed));
		acc(16'h4000, 1'b1, 1'b0, 1'b0, 8'h00);
		apb(1'b1, PMD_OFF_SRAM_BASE, 32'h7, 33'h0);
		sb = 3'h7;
		acc(16'hE000 | (16'($urandom) & 16'h1FFF), 1'b1, 1'b0, 1'b0, 8'h00);
		for (int i = 0; i < 2; i++) begin
			pm = 5'h10 | 5'(i * 15);
			apb(1'b1, PMD_OFF_PORT_MODE, 32'(pm), 33'h0);
			acc(16'hA123 ^ 16'(i), 1'b1, 1'b0, 1'b0, 8'h00);
		end
		acc(16'h50B0, 1'b0, 1'b1, 1'b0, 8'h05);
		acc(16'h50B0, 1'b1, 1'b0, 1'b0, 8'h00);
		acc(16'h50C0, 1'b1, 1'b0, 1'b0, 8'h00);
		acc(16'h5000, 1'b1, 1'b0, 1'b0, 8'h00);
		acc(16'h6080, 1'b1, 1'b0, 1'b0, 8'h00);
		acc(16'h9000, 1'b1, 1'b0, 1'b0, 8'h00);
		acc(16'h9000, 1'b0, 1'b0, 1'b1, 8'h00);
		acc(16'h1000, 1'b0, 1'b0, 1'b1, 8'h00);
		apb(1'b0, PMD_OFF_STATUS, 32'h0, 33'({map, pg}));
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		st_rst();
		apb(1'b0, PMD_OFF_STATUS, 32'h0, 33'h600);
		acc(16'h8000, 1'b1, 1'b0, 1'b0, 8'h00);
		acc(16'h4000, 1'b1, 1'b0, 1'b0, 8'h00);
		repeat (3) @(posedge clk);
		end_sim();
	end
endmodule
`default_nettype wire
